// ---- pcsrs_clock_reset.sv ----
// Functional notes
// - Boot base low reads 0xFF01 during internal reset, 0xFF00 after.
// - Thirty-two bit sum over boot words, split high then low.
// - Boot base pair supplies upper address of code-load page accesses.
// - Auto-detect measures rate; writing it one restarts and reloads default.
// - Rate code equals number of 8 kHz multiples minus one.
// - Result accepted only after nine consistent frame periods; default until then.
// - Default code kept until frame sync and bit clock both toggle.
// - Generate bit makes frame sync internally; otherwise taken from pin.
// - Backup-to-primary switch when redundant clock failed, primary good.
// - Primary-to-backup switch when primary clock failed, redundant good.
// - Status shows PLL, primary and redundant clock failure flags.
// - Power-up flag set by power-on reset, cleared by writing zero.
// - Pin flag cleared by power-on, set by reset pin, writable.
// - Watchdog flag set when reset pin and watchdog both low.
// - Host reset bit triggers full reset and keeps its written value.
// - Reset cause flags decode into boot action.
// - Active highway bit writable; hardware switching may change it.
// - Reset cause flags copied into low nibble of reset type register.
`include "pcsrs_params.svh"

module pcsrs_clock_reset
	import pcsrs_pkg::*;
#(
	parameter int FAIL_CYCLES      = `PCSRS_FAIL_CYCLES,
	parameter int INT_RESET_CYCLES = `PCSRS_INT_RESET_CYCLES,
	parameter int DETECT_PERIODS   = `PCSRS_DETECT_PERIODS
) (
	// Clocks and reset
	input  wire logic           ref_clk,
	input  wire logic           rst,
	input  wire logic           primaryBitClock,
	input  wire logic           redundantBitClock,
	// Frame sync pins
	input  wire logic           primaryFrameSyncIn,
	output logic                primaryFrameSyncOut,
	output logic                primaryFrameSyncOe,
	input  wire logic           redundantFrameSyncIn,
	output logic                redundantFrameSyncOut,
	output logic                redundantFrameSyncOe,
	// Register port
	input  wire logic [7:0]     regAddr,
	input  wire logic           regWrite,
	input  wire logic           regRead,
	input  wire logic [15:0]    regWdata,
	output logic      [15:0]    regRdata,
	output logic                regRvalid,
	// Boot load path
	input  wire logic           bootWordValid,
	input  wire logic [15:0]    bootWord,
	input  wire logic [7:0]     bootPageOffset,
	output logic      [29:0]    bootAccessAddr,
	// System pins
	input  wire logic           rstPinN,
	input  wire logic           watchdogOutputLowN,
	input  wire logic           pllLocked,
	// Status
	output logic                internalResetActive,
	output pcsrs_boot_e         bootAction,
	output logic                activeHighwaySelect
);

	if (FAIL_CYCLES < 2 || FAIL_CYCLES > 65535) begin : gFailChk
		$error("FAIL_CYCLES out of range");
	end
	if (INT_RESET_CYCLES < 1 || INT_RESET_CYCLES > 65535) begin : gRstChk
		$error("INT_RESET_CYCLES out of range");
	end
	if (DETECT_PERIODS < 2 || DETECT_PERIODS > 15) begin : gDetChk
		$error("DETECT_PERIODS out of range");
	end

	localparam logic [15:0] FAIL_LAST  = 16'(FAIL_CYCLES - 1);
	localparam logic [15:0] RESET_LAST = 16'(INT_RESET_CYCLES - 1);
	localparam logic [3:0]  DET_LAST   = 4'(DETECT_PERIODS - 1);
	localparam logic [13:0] CNT_LIMIT  = 14'h2000;

	function automatic logic [7:0] selOffset(input int h);
		selOffset = (h == 0) ? `PCSRS_OFF_SEL_PRI : `PCSRS_OFF_SEL_RED;
	endfunction : selOffset

	function automatic pcsrs_boot_e decodeCause(input logic [3:0] f);
		if (!f[0]) begin
			decodeCause = BOOT_STRAPS;
		end else if (f[3:1] == 3'b000) begin
			decodeCause = BOOT_FULL;
		end else if (f[3:1] == 3'b010) begin
			decodeCause = BOOT_APP_ONLY;
		end else begin
			decodeCause = BOOT_RESERVED;
		end
	endfunction : decodeCause

	wire logic [1:0] linkClk  = {redundantBitClock, primaryBitClock};
	wire logic [1:0] fsPin    = {redundantFrameSyncIn, primaryFrameSyncIn};

	pcsrs_sel_s       selQ [2];
	logic [1:0]       restartTogQ;
	logic [1:0]       actTogW;
	logic [1:0]       resTogW;
	pcsrs_rate_t      resDataW [2];
	logic [1:0]       fsOutW;
	logic [1:0]       fsOeW;
	logic             resetDoneQ;
	logic [15:0]      resetCntQ;

	// Link-side logic, one copy per highway
	for (genvar h = 0; h < 2; h++) begin : gLink
		logic [1:0]       lrstQ;
		pcsrs_link_cfg_s  cfgIn;
		pcsrs_link_cfg_s  cS1Q;
		pcsrs_link_cfg_s  cS2Q;
		pcsrs_link_cfg_s  cS3Q;
		pcsrs_link_cfg_s  cfgQ;
		logic             fsInQ;
		logic             fsPrevQ;
		pcsrs_rate_t      genCntQ;
		logic             genPulseQ;
		logic             genOeQ;
		logic             restartSeenQ;
		pcsrs_det_e       stateQ;
		logic [13:0]      edgeCntQ;
		logic [13:0]      lastCntQ;
		logic [3:0]       matchCntQ;
		pcsrs_rate_t      resDataQ;
		logic             resTogQ;
		logic             actTogQ;
		logic             linkRst;
		logic             genTick;
		logic             frameEvt;
		logic             restart;
		logic             cntOk;

		// Local reset, released on the link clock
		always_ff @(posedge linkClk[h] or posedge rst) begin
			if (rst) begin
				lrstQ <= 2'b11;
			end else begin
				lrstQ <= {lrstQ[0], 1'b0};
			end
		end
		assign linkRst = lrstQ[1];

		// Configuration crossing: taken once two stages agree
		assign cfgIn = '{restartTog: restartTogQ[h], syncGen: selQ[h].syncGen,
			rate: selQ[h].rate};
		always_ff @(posedge linkClk[h] or posedge linkRst) begin
			if (linkRst) begin
				cS1Q <= '{restartTog: 1'b0, syncGen: 1'b0, rate: `PCSRS_RATE_DEFAULT};
				cS2Q <= '{restartTog: 1'b0, syncGen: 1'b0, rate: `PCSRS_RATE_DEFAULT};
				cS3Q <= '{restartTog: 1'b0, syncGen: 1'b0, rate: `PCSRS_RATE_DEFAULT};
				cfgQ <= '{restartTog: 1'b0, syncGen: 1'b0, rate: `PCSRS_RATE_DEFAULT};
			end else begin
				cS1Q <= cfgIn;
				cS2Q <= cS1Q;
				cS3Q <= cS2Q;
				if (cS2Q == cS3Q) begin
					cfgQ <= cS3Q;
				end
			end
		end

		assign genTick  = (genCntQ == cfgQ.rate);
		assign frameEvt = cfgQ.syncGen ? genTick : (fsInQ & ~fsPrevQ);
		always_ff @(posedge linkClk[h] or posedge linkRst) begin
			if (linkRst) begin
				fsInQ     <= 1'b0;
				fsPrevQ   <= 1'b0;
				genCntQ   <= '0;
				genPulseQ <= 1'b0;
				genOeQ    <= 1'b0;
			end else begin
				fsInQ     <= fsPin[h];
				fsPrevQ   <= fsInQ;
				genCntQ   <= (cfgQ.syncGen && !genTick) ? genCntQ + 1'b1 : '0;
				genPulseQ <= cfgQ.syncGen & genTick;
				// Enable from the same sample as the pulse, so a last pulse is driven
				genOeQ    <= cfgQ.syncGen;
			end
		end
		assign fsOutW[h] = genPulseQ;
		assign fsOeW[h]  = genOeQ;

		// Edge count per frame, repeated before acceptance
		assign restart = (cfgQ.restartTog != restartSeenQ);
		assign cntOk   = (edgeCntQ != 14'h0000) && (edgeCntQ <= CNT_LIMIT);
		always_ff @(posedge linkClk[h] or posedge linkRst) begin
			if (linkRst) begin
				stateQ       <= DET_WAIT;
				restartSeenQ <= 1'b0;
				edgeCntQ     <= '0;
				lastCntQ     <= '0;
				matchCntQ    <= '0;
				resDataQ     <= `PCSRS_RATE_DEFAULT;
				resTogQ      <= 1'b0;
			end else if (restart) begin
				restartSeenQ <= cfgQ.restartTog;
				stateQ       <= DET_WAIT;
				matchCntQ    <= '0;
			end else begin
				if (edgeCntQ != 14'h3fff) begin
					edgeCntQ <= edgeCntQ + 1'b1;
				end
				case (stateQ)
					DET_WAIT: begin
						// Nothing measured before a frame edge
						if (frameEvt) begin
							edgeCntQ  <= 14'h0001;
							matchCntQ <= '0;
							stateQ    <= DET_MEASURE;
						end
					end
					DET_MEASURE: begin
						if (frameEvt) begin
							edgeCntQ <= 14'h0001;
							lastCntQ <= edgeCntQ;
							if (cntOk && edgeCntQ == lastCntQ && matchCntQ != '0) begin
								matchCntQ <= matchCntQ + 1'b1;
								// Publish after the ninth consistent period
								if (matchCntQ == DET_LAST) begin
									// Code is edges per frame minus one
									resDataQ <= 13'(edgeCntQ - 14'h0001);
									resTogQ  <= ~resTogQ;
									stateQ   <= DET_DONE;
								end
							end else begin
								matchCntQ <= cntOk ? 4'h1 : 4'h0;
							end
						end
					end
					DET_DONE: begin
						stateQ <= DET_DONE;
					end
					default: begin
						stateQ <= DET_WAIT;
					end
				endcase
			end
		end

		// Frame activity for failure watch
		always_ff @(posedge linkClk[h] or posedge linkRst) begin
			if (linkRst) begin
				actTogQ <= 1'b0;
			end else if (frameEvt) begin
				actTogQ <= ~actTogQ;
			end
		end

		assign actTogW[h]  = actTogQ;
		assign resTogW[h]  = resTogQ;
		assign resDataW[h] = resDataQ;
	end

	// Pin inputs and link toggles enter through three stages
	logic [2:0] pinS1Q, pinS2Q, pinS3Q, pinQ;
	logic [1:0] actS1Q, actS2Q, actS3Q, actSeenQ;
	logic [1:0] resS1Q, resS2Q, resS3Q, resSeenQ;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pinS1Q   <= 3'b110;
			pinS2Q   <= 3'b110;
			pinS3Q   <= 3'b110;
			pinQ     <= 3'b110;
			actS1Q   <= '0;
			actS2Q   <= '0;
			actS3Q   <= '0;
			resS1Q   <= '0;
			resS2Q   <= '0;
			resS3Q   <= '0;
		end else begin
			pinS1Q   <= {rstPinN, watchdogOutputLowN, pllLocked};
			pinS2Q   <= pinS1Q;
			pinS3Q   <= pinS2Q;
			if (pinS2Q == pinS3Q) begin
				pinQ <= pinS3Q;
			end
			actS1Q   <= actTogW;
			actS2Q   <= actS1Q;
			actS3Q   <= actS2Q;
			resS1Q   <= resTogW;
			resS2Q   <= resS1Q;
			resS3Q   <= resS2Q;
		end
	end

	logic       pinResetActive;
	logic       busWrite;
	logic       statWrite;
	logic       hostResetWr;
	logic       fullResetReq;
	logic       resetFinish;
	logic [1:0] actEvt;
	logic [1:0] resAcc;
	logic [1:0] failQ;
	logic [15:0] failCntQ [2];

	assign pinResetActive = ~pinQ[2];
	assign busWrite       = regWrite & resetDoneQ;
	assign statWrite      = busWrite && (regAddr == `PCSRS_OFF_STAT);
	// Host reset bit starts a full reset
	assign hostResetWr    = statWrite & regWdata[`PCSRS_STAT_HOST_BIT];
	assign fullResetReq   = hostResetWr | pinResetActive;
	assign resetFinish    = !resetDoneQ && (resetCntQ == RESET_LAST) && !fullResetReq;

	for (genvar h = 0; h < 2; h++) begin : gEvt
		assign actEvt[h] = (actS2Q[h] == actS3Q[h]) && (actS3Q[h] != actSeenQ[h]);
		assign resAcc[h] = (resS2Q[h] == resS3Q[h]) && (resS3Q[h] != resSeenQ[h]);
	end

	// Clock failure: no frame activity within the timeout
	for (genvar h = 0; h < 2; h++) begin : gFail
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				actSeenQ[h] <= 1'b0;
				failCntQ[h] <= '0;
				failQ[h]    <= 1'b1;
			end else if (actEvt[h]) begin
				actSeenQ[h] <= actS3Q[h];
				failCntQ[h] <= '0;
				failQ[h]    <= 1'b0;
			end else if (failCntQ[h] == FAIL_LAST) begin
				failQ[h]    <= 1'b1;
			end else begin
				failCntQ[h] <= failCntQ[h] + 1'b1;
			end
		end
	end

	// Select registers
	for (genvar h = 0; h < 2; h++) begin : gSel
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				selQ[h]        <= `PCSRS_SEL_RST;
				restartTogQ[h] <= 1'b0;
				resSeenQ[h]    <= 1'b0;
			end else begin
				if (resAcc[h]) begin
					resSeenQ[h] <= resS3Q[h];
				end
				if (fullResetReq) begin
					selQ[h]        <= `PCSRS_SEL_RST;
					restartTogQ[h] <= ~restartTogQ[h];
				end else if (busWrite && regAddr == selOffset(h)) begin
					selQ[h] <= regWdata;
					// Writing detect one reloads default and restarts
					if (regWdata[15]) begin
						selQ[h].rate   <= `PCSRS_RATE_DEFAULT;
						restartTogQ[h] <= ~restartTogQ[h];
					end
				end else if (resAcc[h] && selQ[h].detectEn) begin
					// Measured rate stored while detection enabled
					selQ[h].rate <= resDataW[h];
				end
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			resetCntQ  <= '0;
			resetDoneQ <= 1'b0;
		end else if (fullResetReq) begin
			resetCntQ  <= '0;
			resetDoneQ <= 1'b0;
		end else if (!resetDoneQ) begin
			if (resetCntQ == RESET_LAST) begin
				resetDoneQ <= 1'b1;
			end else begin
				resetCntQ <= resetCntQ + 1'b1;
			end
		end
	end
	assign internalResetActive = ~resetDoneQ;

	// Reset cause flags
	logic       porQ, pinFlagQ, wdtFlagQ, hostQ;
	logic [3:0] rtypeQ;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			porQ       <= 1'b1;
			pinFlagQ   <= 1'b0;
			wdtFlagQ   <= 1'b0;
			hostQ      <= 1'b0;
			rtypeQ     <= '0;
			bootAction <= BOOT_STRAPS;
		end else begin
			// Power-up flag cleared only by software
			if (statWrite) begin
				porQ  <= regWdata[`PCSRS_STAT_POR_BIT];
				hostQ <= regWdata[`PCSRS_STAT_HOST_BIT];
			end
			// Pin flag set by the reset pin
			if (pinResetActive) begin
				pinFlagQ <= 1'b1;
			end else if (statWrite) begin
				pinFlagQ <= regWdata[`PCSRS_STAT_PIN_BIT];
			end
			// Watchdog flag when pin and watchdog both low
			if (pinResetActive && !pinQ[1]) begin
				wdtFlagQ <= 1'b1;
			end else if (statWrite) begin
				wdtFlagQ <= regWdata[`PCSRS_STAT_WDT_BIT];
			end
			if (resetFinish) begin
				// Cause nibble copied at end of reset
				rtypeQ     <= {porQ, pinFlagQ, wdtFlagQ, hostQ};
				bootAction <= decodeCause({porQ, pinFlagQ, wdtFlagQ, hostQ});
			end
		end
	end

	// Active highway
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			activeHighwaySelect <= 1'b0;
		end else if (fullResetReq) begin
			activeHighwaySelect <= 1'b0;
		end else if (activeHighwaySelect && selQ[1].autoSwitch && failQ[1] && !failQ[0]) begin
			activeHighwaySelect <= 1'b0;
		end else if (!activeHighwaySelect && selQ[0].autoSwitch && failQ[0] && !failQ[1]) begin
			activeHighwaySelect <= 1'b1;
		end else if (busWrite && regAddr == `PCSRS_OFF_HIWAY) begin
			activeHighwaySelect <= regWdata[`PCSRS_HIWAY_BIT];
		end
	end

	// Boot checksum and window base
	logic [31:0]                  sumQ;
	logic [`PCSRS_BASE_HI_W-1:0]  baseHiQ;
	logic [7:0]                   baseLoQ;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sumQ    <= '0;
			baseHiQ <= `PCSRS_BASE_HI_RST;
			baseLoQ <= `PCSRS_BASE_LO_RST;
		end else if (fullResetReq) begin
			sumQ    <= '0;
			baseHiQ <= `PCSRS_BASE_HI_RST;
			baseLoQ <= `PCSRS_BASE_LO_RST;
		end else begin
			// Accumulation wins over a host write
			if (bootWordValid) begin
				sumQ <= sumQ + {16'h0000, bootWord};
			end else if (busWrite && regAddr == `PCSRS_OFF_SUM_HI) begin
				sumQ[31:16] <= regWdata;
			end else if (busWrite && regAddr == `PCSRS_OFF_SUM_LO) begin
				sumQ[15:0] <= regWdata;
			end
			if (busWrite && regAddr == `PCSRS_OFF_BASE_HI) begin
				baseHiQ <= regWdata[`PCSRS_BASE_HI_W-1:0];
			end
			if (busWrite && regAddr == `PCSRS_OFF_BASE_LO) begin
				baseLoQ <= regWdata[15:8];
			end
		end
	end

	// Code-load page address from window base
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bootAccessAddr <= '0;
		end else begin
			bootAccessAddr <= {baseHiQ, baseLoQ, bootPageOffset};
		end
	end

	// Read port
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			regRdata  <= '0;
			regRvalid <= 1'b0;
		end else begin
			regRvalid <= regRead;
			if (!regRead) begin
				regRdata <= regRdata;
			end else if (regAddr == `PCSRS_OFF_BASE_LO) begin
				// Low bit shows reset still in progress
				regRdata <= {baseLoQ, 7'h00, ~resetDoneQ};
			end else if (!resetDoneQ) begin
				regRdata <= '0;
			end else if (regAddr == `PCSRS_OFF_SUM_HI) begin
				regRdata <= sumQ[31:16];
			end else if (regAddr == `PCSRS_OFF_SUM_LO) begin
				regRdata <= sumQ[15:0];
			end else if (regAddr == `PCSRS_OFF_BASE_HI) begin
				regRdata <= {2'b00, baseHiQ};
			end else if (regAddr == `PCSRS_OFF_SEL_RED) begin
				regRdata <= selQ[1];
			end else if (regAddr == `PCSRS_OFF_SEL_PRI) begin
				regRdata <= selQ[0];
			end else if (regAddr == `PCSRS_OFF_STAT) begin
				regRdata <= {5'h00, ~pinQ[0], failQ[1], failQ[0],
					4'h0, porQ, pinFlagQ, wdtFlagQ, hostQ};
			end else if (regAddr == `PCSRS_OFF_HIWAY) begin
				regRdata <= {2'b00, activeHighwaySelect, 13'h0000};
			end else if (regAddr == `PCSRS_OFF_RTYPE) begin
				regRdata <= {12'h000, rtypeQ};
			end else begin
				regRdata <= '0;
			end
		end
	end

	assign primaryFrameSyncOut   = fsOutW[0];
	assign primaryFrameSyncOe    = fsOeW[0];
	assign redundantFrameSyncOut = fsOutW[1];
	assign redundantFrameSyncOe  = fsOeW[1];

endmodule : pcsrs_clock_reset

// ---- pcsrs_clock_reset_chk.sv ----
module pcsrs_clock_reset_chk
	import pcsrs_pkg::*;
(
	// Clocks and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        primaryBitClock,
	// Register port
	input wire logic [7:0]  regAddr,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [15:0] regWdata,
	input wire logic [15:0] regRdata,
	input wire logic        regRvalid,
	// Boot path and pins
	input wire logic [7:0]  bootPageOffset,
	input wire logic [29:0] bootAccessAddr,
	input wire logic        rstPinN,
	input wire logic        pllLocked,
	input wire logic        primaryFrameSyncOut,
	input wire logic        primaryFrameSyncOe,
	// Status
	input wire logic        internalResetActive,
	input wire pcsrs_boot_e bootAction
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_read_answer: assert property (regRead |=> regRvalid)
		else $error("read not answered");
	chk_busy_poll: assert property (regRead && regAddr == 8'h07
		|=> regRdata[0] == $past(internalResetActive))
		else $error("busy bit wrong");
	chk_busy_quiet: assert property (regRead && internalResetActive
		&& regAddr != 8'h07 |=> regRdata == 16'h0000)
		else $error("read while busy not zero");
	chk_page_addr: assert property (!internalResetActive [*2]
		|-> bootAccessAddr[7:0] == $past(bootPageOffset))
		else $error("page offset not passed");
	chk_pll_good: assert property (pllLocked [*6] ##0 regRead
		&& regAddr == 8'h0a && !internalResetActive |=> !regRdata[10])
		else $error("pll flag set while locked");
	chk_pll_bad: assert property (!pllLocked [*6] ##0 regRead
		&& regAddr == 8'h0a && !internalResetActive |=> regRdata[10])
		else $error("pll flag clear while unlocked");
	chk_host_reset: assert property (regWrite && regAddr == 8'h0a
		&& regWdata[0] && !internalResetActive |-> ##[1:3] internalResetActive)
		else $error("host reset not started");
	chk_pin_reset: assert property (!rstPinN [*6] |-> internalResetActive)
		else $error("pin reset not held");
	chk_action_time: assert property ($changed(bootAction)
		|-> $past(internalResetActive) || $past(internalResetActive, 2))
		else $error("boot action moved outside reset");
	chk_gen_pulse: assert property (@(posedge primaryBitClock)
		primaryFrameSyncOut |-> primaryFrameSyncOe ##1 !primaryFrameSyncOut)
		else $error("generated sync not one clock");

	cover property (regRead && regAddr == 8'h07 && internalResetActive);
	cover property (bootAction == BOOT_APP_ONLY);
	cover property ($rose(primaryFrameSyncOe));
endmodule : pcsrs_clock_reset_chk

bind pcsrs_clock_reset pcsrs_clock_reset_chk pcsrs_clock_reset_chk_i (.ref_clk, .rst,
	.primaryBitClock, .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .regRvalid,
	.bootPageOffset, .bootAccessAddr, .rstPinN, .pllLocked, .primaryFrameSyncOut,
	.primaryFrameSyncOe, .internalResetActive, .bootAction);

// ---- pcsrs_hiway_src.sv ----
module pcsrs_hiway_src #(
	parameter int EDGES = 64,
	parameter int OFS   = 1
) (
	// Control
	input  wire logic run,
	// Highway pins
	output logic      bitClk,
	output logic      frameSync
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt;
	initial begin
		bitClk = 1'b0;
		frameSync = 1'b0;
		cnt = 0;
		#(OFS);
		forever begin
			#7.5;
			if (run) begin
				bitClk = ~bitClk;
				if (!bitClk) begin
					cnt = (cnt + 1) % EDGES;
					frameSync = (cnt == 0);
				end
			end else begin
				frameSync = 1'b0;
			end
		end
	end
endmodule : pcsrs_hiway_src

// ---- pcsrs_params.svh ----
`ifndef PCSRS_PARAMS_SVH
`define PCSRS_PARAMS_SVH

// Register offsets
`define PCSRS_OFF_SUM_HI    8'h04
`define PCSRS_OFF_SUM_LO    8'h05
`define PCSRS_OFF_BASE_HI   8'h06
`define PCSRS_OFF_BASE_LO   8'h07
`define PCSRS_OFF_SEL_RED   8'h08
`define PCSRS_OFF_SEL_PRI   8'h09
`define PCSRS_OFF_STAT      8'h0a
`define PCSRS_OFF_HIWAY     8'h0b
`define PCSRS_OFF_RTYPE     8'h16

// Field positions
`define PCSRS_STAT_PLL_BIT  10
`define PCSRS_STAT_RED_BIT  9
`define PCSRS_STAT_PRI_BIT  8
`define PCSRS_STAT_POR_BIT  3
`define PCSRS_STAT_PIN_BIT  2
`define PCSRS_STAT_WDT_BIT  1
`define PCSRS_STAT_HOST_BIT 0
`define PCSRS_HIWAY_BIT     13
`define PCSRS_RATE_W        13
`define PCSRS_BASE_HI_W     14

// Reset values
`define PCSRS_SEL_RST       16'h92fb
`define PCSRS_RATE_DEFAULT  13'h12fb
`define PCSRS_BASE_HI_RST   14'h0000
`define PCSRS_BASE_LO_RST   8'hff

// Timing
`define PCSRS_CLK_MHZ           10
`define PCSRS_FAIL_TIME_US      250
`define PCSRS_FAIL_CYCLES       (`PCSRS_FAIL_TIME_US * `PCSRS_CLK_MHZ)
`define PCSRS_INT_RESET_US      10
`define PCSRS_INT_RESET_CYCLES  (`PCSRS_INT_RESET_US * `PCSRS_CLK_MHZ)
`define PCSRS_DETECT_PERIODS    9

`endif

// ---- pcsrs_pkg.sv ----
`include "pcsrs_params.svh"

package pcsrs_pkg;

	// Highway select register layout
	typedef struct packed {
		logic                       detectEn;
		logic                       autoSwitch;
		logic                       syncGen;
		logic [`PCSRS_RATE_W-1:0]   rate;
	} pcsrs_sel_s;

	// Link-side configuration carried across the crossing
	typedef struct packed {
		logic                       restartTog;
		logic                       syncGen;
		logic [`PCSRS_RATE_W-1:0]   rate;
	} pcsrs_link_cfg_s;

	typedef enum logic [3:0] {
		BOOT_STRAPS   = 4'b0001,
		BOOT_FULL     = 4'b0010,
		BOOT_APP_ONLY = 4'b0100,
		BOOT_RESERVED = 4'b1000
	} pcsrs_boot_e;

	typedef enum logic [2:0] {
		DET_WAIT    = 3'b001,
		DET_MEASURE = 3'b010,
		DET_DONE    = 3'b100
	} pcsrs_det_e;

	typedef logic [`PCSRS_RATE_W-1:0] pcsrs_rate_t;

endpackage : pcsrs_pkg

// ---- tb.sv ----
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin miscompares++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module tb
	import pcsrs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        ref_clk, rst, rstPinN, watchdogOutputLowN, pllLocked;
	logic        priClk, redClk, priFsSrc, redFsSrc, priRun, redRun;
	logic        priFsOut, priFsOe, redFsOut, redFsOe, regWrite, regRead, regRvalid;
	logic [7:0]  regAddr, bootPageOffset;
	logic [15:0] regWdata, regRdata, bootWord;
	logic        bootWordValid, internalResetActive, activeHighwaySelect;
	logic [29:0] bootAccessAddr;
	pcsrs_boot_e bootAction;
	int          miscompares = 0;
	int          nCompared = 0;

	pcsrs_hiway_src pri_src_i (.run(priRun), .bitClk(priClk),
		.frameSync(priFsSrc));
	pcsrs_hiway_src #(.EDGES(128), .OFS(4)) red_src_i (.run(redRun), .bitClk(redClk),
		.frameSync(redFsSrc));
	pcsrs_clock_reset #(.FAIL_CYCLES(50), .INT_RESET_CYCLES(4)) pcsrs_clock_reset_i (
		.ref_clk, .rst, .primaryBitClock(priClk), .redundantBitClock(redClk),
		.primaryFrameSyncIn(priFsOe ? priFsOut : priFsSrc),
		.primaryFrameSyncOut(priFsOut), .primaryFrameSyncOe(priFsOe),
		.redundantFrameSyncIn(redFsOe ? redFsOut : redFsSrc),
		.redundantFrameSyncOut(redFsOut), .redundantFrameSyncOe(redFsOe),
		.regAddr, .regWrite, .regRead, .regWdata, .regRdata, .regRvalid,
		.bootWordValid, .bootWord, .bootPageOffset, .bootAccessAddr, .rstPinN,
		.watchdogOutputLowN, .pllLocked, .internalResetActive, .bootAction,
		.activeHighwaySelect);

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic printVerdict;
		$display("compared %0d, miscompares %0d", nCompared, miscompares);
		if (miscompares == 0 && nCompared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : printVerdict

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		regAddr = a;
		regWdata = d;
		regWrite = 1'b1;
		cyc(1);
		regWrite = 1'b0;
		cyc(1);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		regAddr = a;
		regRead = 1'b1;
		cyc(1);
		regRead = 1'b0;
		`CHK(regRvalid, 1'b1)
		`CHK(regRdata & m, e)
		cyc(1);
	endtask : rc

	task automatic waitIdle;
		int i;
		cyc(3);
		for (i = 0; i < 300 && internalResetActive !== 1'b0; i++) cyc(1);
		if (internalResetActive !== 1'b0) begin
			miscompares++;
			printVerdict();
		end
	endtask : waitIdle

	initial begin
		rst = 1'b1;
		rstPinN = 1'b1;
		watchdogOutputLowN = 1'b1;
		pllLocked = 1'b1;
		priRun = 1'b1;
		redRun = 1'b1;
		regAddr = 8'h00;
		regWdata = 16'h0000;
		regWrite = 1'b0;
		regRead = 1'b0;
		bootWord = 16'h0000;
		bootWordValid = 1'b0;
		bootPageOffset = 8'h00;
		cyc(10);
		rst = 1'b0;
		rc(8'h07, 16'hffff, 16'hff01);
		waitIdle();
		rc(8'h07, 16'hffff, 16'hff00);
		`CHK(bootAction, BOOT_STRAPS)
		rc(8'h0a, 16'h000f, 16'h0008);
		rc(8'h09, 16'hffff, 16'h92fb);
		rc(8'h08, 16'hffff, 16'h92fb);
		cyc(300);
		rc(8'h09, 16'hffff, 16'h803f);
		rc(8'h08, 16'hffff, 16'h807f);
		wr(8'h09, 16'h8000);
		rc(8'h09, 16'hffff, 16'h92fb);
		for (int k = 0; k < 3; k++) begin
			bootWord = (k < 2) ? 16'hffff : 16'h0002;
			bootWordValid = 1'b1;
			cyc(1);
		end
		bootWordValid = 1'b0;
		rc(8'h04, 16'hffff, 16'h0002);
		rc(8'h05, 16'hffff, 16'h0000);
		wr(8'h05, 16'h1234);
		rc(8'h05, 16'hffff, 16'h1234);
		wr(8'h06, 16'h3abc);
		wr(8'h07, 16'h1200);
		bootPageOffset = 8'h34;
		cyc(2);
		`CHK(bootAccessAddr, {14'h3abc, 8'h12, 8'h34})
		wr(8'h09, 16'h403f);
		priRun = 1'b0;
		cyc(100);
		rc(8'h0a, 16'h0700, 16'h0100);
		`CHK(activeHighwaySelect, 1'b1)
		rc(8'h0b, 16'h2000, 16'h2000);
		priRun = 1'b1;
		redRun = 1'b0;
		wr(8'h08, 16'h407f);
		cyc(100);
		`CHK(activeHighwaySelect, 1'b0)
		rc(8'h0a, 16'h0700, 16'h0200);
		redRun = 1'b1;
		cyc(100);
		wr(8'h0b, 16'h2000);
		`CHK(activeHighwaySelect, 1'b1)
		wr(8'h0b, 16'h0000);
		pllLocked = 1'b0;
		cyc(8);
		rc(8'h0a, 16'h0400, 16'h0400);
		pllLocked = 1'b1;
		wr(8'h09, 16'h203f);
		cyc(10);
		`CHK(priFsOe, 1'b1)
		`CHK(redFsOe, 1'b0)
		cyc(20);
		wr(8'h09, 16'h003f);
		wr(8'h0a, 16'h0000);
		rc(8'h0a, 16'h000f, 16'h0000);
		wr(8'h0a, 16'h0001);
		waitIdle();
		rc(8'h16, 16'h000f, 16'h0001);
		rc(8'h0a, 16'h000f, 16'h0001);
		rc(8'h09, 16'hffff, 16'h92fb);
		`CHK(bootAction, BOOT_FULL)
		rstPinN = 1'b0;
		cyc(8);
		rc(8'h07, 16'h00ff, 16'h0001);
		rc(8'h09, 16'hffff, 16'h0000);
		rstPinN = 1'b1;
		waitIdle();
		rc(8'h16, 16'h000f, 16'h0005);
		`CHK(bootAction, BOOT_APP_ONLY)
		rstPinN = 1'b0;
		watchdogOutputLowN = 1'b0;
		cyc(8);
		rstPinN = 1'b1;
		watchdogOutputLowN = 1'b1;
		waitIdle();
		rc(8'h16, 16'h000f, 16'h0007);
		`CHK(bootAction, BOOT_RESERVED)
		printVerdict();
	end
endmodule : tb
